// file: rtl/flog_fifo.sv
// Fault snapshot FIFO with a registered output stage
`timescale 1ns/1ps
module flog_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // Drain side
  output logic                  o_rd_valid,
  output logic [WIDTH-1:0]      o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  logic             push;
  logic             pop;

  // Handshake terms; the head moves out when the output stage is free
  assign o_wr_ready = (cnt_r != FULL_CNT);
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = (cnt_r != '0) && (!o_rd_valid || i_rd_ready);

  // Storage write
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wp_r] <= i_wr_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  // Output stage
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else if (pop) begin
      o_rd_valid <= 1'b1;
      o_rd_data  <= mem[rp_r];
    end else if (i_rd_ready) begin
      o_rd_valid <= 1'b0;
    end
  end
endmodule

// file: rtl/led_sink_ctrl.sv
// Serial control logic of the sixteen-channel LED sink driver
`timescale 1ns/1ps
module led_sink_ctrl
  import led_sink_pkg::*;
#(
  parameter int CH = led_sink_pkg::CHANNELS
) (
  // Clock and reset
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_sys_rst,
  // Serial pins from the controller
  input  wire logic                            i_serial_clk,
  input  wire logic                            i_serial_in,
  input  wire logic                            i_latch_strobe,
  input  wire logic                            i_output_enable_n,
  output logic                                 o_serial_out,
  // Per-channel fault sense from the output stage
  input  wire logic [led_sink_pkg::CHANNELS-1:0] i_channel_fault,
  // Channel drive and current regulator settings
  output logic [led_sink_pkg::CHANNELS-1:0]    o_sink_channels,
  output logic [led_sink_pkg::CFG_WIDTH-1:0]   o_cfg_word,
  output logic [led_sink_pkg::GAIN_WIDTH-1:0]  o_gain_code,
  output logic                                 o_mode_special,
  // Fault snapshot stream
  output logic                                 o_flog_valid,
  output logic [led_sink_pkg::CHANNELS-1:0]    o_flog_data,
  input  wire logic                            i_flog_ready
);
  import led_sink_pkg::*;

  logic [SYNC_W-1:0]    sync1_r;
  logic [SYNC_W-1:0]    sync2_r;
  logic                 sclk_d_r;
  logic                 strobe_d_r;
  logic                 sclk_rise;
  logic                 strobe_rise;
  logic                 oe_n_s;
  logic                 strobe_s;
  logic [CH-1:0]        fault_s;
  mode_t                mode_r;
  logic [1:0]           low_edges_r;
  logic                 switch_evt;
  logic                 fault_load;
  logic [CH-1:0]        sr_r;
  logic [CH-1:0]        out_latch_r;
  logic [CFG_WIDTH-1:0] cfg_r;
  logic [CH-1:0]        err_r;
  logic [CH-1:0]        err_nxt;
  logic [SENSE_CNT_W-1:0] sense_cnt_r;
  logic                 sense_done;
  logic                 clear_err;
  logic                 flog_pend_r;
  logic                 flog_wr_ready;
  logic [CH-1:0]        flog_word_r;

  // Two-stage synchroniser for every pin; strobe resets low, enable high
  // pull defaults
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {i_output_enable_n, i_latch_strobe, i_serial_in, i_serial_clk,
                  i_channel_fault};
      sync2_r <= sync1_r;
    end
  end

  assign fault_s  = sync2_r[CH-1:0];
  assign oe_n_s   = sync2_r[SY_OE_N];
  assign strobe_s = sync2_r[SY_STROBE];

  // Edge detectors on the synchronised clock and strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sclk_d_r   <= 1'b0;
      strobe_d_r <= STROBE_RST;
    end else begin
      sclk_d_r   <= sync2_r[SY_SCLK];
      strobe_d_r <= strobe_s;
    end
  end

  assign sclk_rise   = sync2_r[SY_SCLK] && !sclk_d_r;
  assign strobe_rise = strobe_s && !strobe_d_r;

  // Enable pulse width in serial clock edges; one low edge means a mode switch
  // pulse detection
  assign switch_evt = sclk_rise && oe_n_s && (low_edges_r == 2'd1);
  assign fault_load = sclk_rise && oe_n_s && (low_edges_r >= 2'd2)
                      && (mode_r == MODE_SPECIAL);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      low_edges_r <= 2'd0;
    end else if (sclk_rise) begin
      if (!oe_n_s) begin
        low_edges_r <= (low_edges_r == 2'd3) ? 2'd3 : low_edges_r + 2'd1;
      end else begin
        low_edges_r <= 2'd0;
      end
    end
  end

  // Mode register; strobe level at the switch edge picks the next mode
  // special mode entry
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_r <= MODE_NORMAL;
    end else if (switch_evt) begin
      case (strobe_s)
        1'b1:    mode_r <= MODE_SPECIAL;
        default: mode_r <= MODE_NORMAL;
      endcase
    end
  end

  // Shift register; a fault load replaces the shift at the read edge
  // serial shift
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sr_r <= SR_RST;
    end else if (fault_load) begin
      sr_r <= err_r;
    end else if (sclk_rise) begin
      sr_r <= {sr_r[CH-2:0], sync2_r[SY_SDI]};
    end
  end

  // Serial output shows the oldest stage
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_serial_out <= 1'b0;
    end else begin
      o_serial_out <= sr_r[CH-1];
    end
  end

  // Output latch is transparent while strobe is high in normal mode
  // strobe latching
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      out_latch_r <= LATCH_RST;
    end else if (strobe_s && mode_r == MODE_NORMAL) begin
      out_latch_r <= sr_r;
    end
  end

  // Configuration latch written on a strobe pulse in special mode
  // configuration write
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cfg_r <= CFG_RST;
    end else if (strobe_rise && mode_r == MODE_SPECIAL) begin
      cfg_r <= sr_r;
    end
  end

  // Channel drive gated by the enable in every mode
  // enable in all modes
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sink_channels <= '0;
    end else begin
      o_sink_channels <= oe_n_s ? '0 : out_latch_r;
    end
  end

  // Regulator settings; low byte is the 256-step gain code
  // gain code
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_cfg_word     <= CFG_RST;
      o_gain_code    <= CFG_RST[GAIN_WIDTH-1:0];
      o_mode_special <= 1'b0;
    end else begin
      o_cfg_word     <= cfg_r;
      o_gain_code    <= cfg_r[GAIN_WIDTH-1:0];
      o_mode_special <= (mode_r == MODE_SPECIAL);
    end
  end

  // Sense timer: faults are trusted only after the enable has been low long enough
  // sense settle time
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sense_cnt_r <= '0;
    end else if (oe_n_s || mode_r != MODE_SPECIAL) begin
      sense_cnt_r <= '0;
    end else if (sense_cnt_r != SENSE_CNT_W'(OE_ERRDET_CYC)) begin
      sense_cnt_r <= sense_cnt_r + 1'b1;
    end
  end

  assign sense_done = (sense_cnt_r == SENSE_CNT_W'(OE_ERRDET_CYC)) && !oe_n_s;
  assign clear_err  = switch_evt && !strobe_s;

  // Sticky error bits; a fault seen in the clearing cycle survives
  // clear on return
  always_comb begin
    err_nxt = clear_err ? '0 : err_r;
    if (sense_done) begin
      err_nxt = err_nxt | fault_s;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      err_r <= '0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // Snapshot of a fault read waits in a holding register until the FIFO has room; reads while it waits are dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      flog_pend_r <= 1'b0;
      flog_word_r <= '0;
    end else if (fault_load && !flog_pend_r) begin
      flog_pend_r <= 1'b1;
      flog_word_r <= err_r;
    end else if (flog_pend_r && flog_wr_ready) begin
      flog_pend_r <= 1'b0;
    end
  end

  // Drain side shows the FIFO head from its registered output stage
  flog_fifo #(
    .WIDTH (CH),
    .DEPTH (FLOG_DEPTH)
  ) u_flog_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_valid (flog_pend_r),
    .i_wr_data  (flog_word_r),
    .o_wr_ready (flog_wr_ready),
    .o_rd_valid (o_flog_valid),
    .o_rd_data  (o_flog_data),
    .i_rd_ready (i_flog_ready)
  );

  // Shift moves the previous stage one place up
  shift_out_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    sclk_rise && !fault_load |=> sr_r[CH-1] == $past(sr_r[CH-2]))
    else $error("shift register did not shift");

  // Enable high blanks the channels
  blank_out_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    oe_n_s |=> o_sink_channels == '0)
    else $error("channels driven while enable high");

  // Strobe pulse in special mode writes the configuration latch
  cfg_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    strobe_rise && mode_r == MODE_SPECIAL |=> cfg_r == $past(sr_r) ##2 o_cfg_word == $past(cfg_r, 1))
    else $error("configuration latch not written");

  // Output latch holds in special mode
  latch_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    mode_r == MODE_SPECIAL && $past(mode_r) == MODE_SPECIAL |-> $stable(out_latch_r))
    else $error("output latch changed in special mode");

  // Return to normal leaves no error bits
  err_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    clear_err |=> err_r == '0 && mode_r == MODE_NORMAL)
    else $error("error bits survived return to normal");

  // Switch edge with strobe high enters special mode
  mode_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    switch_evt && strobe_s |=> mode_r == MODE_SPECIAL ##2 o_mode_special)
    else $error("special mode not entered");

  // Read edge loads the error bits
  fault_load_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    fault_load |=> sr_r == $past(err_r) ##1 o_serial_out == $past(err_r[CH-1], 2))
    else $error("fault status not loaded");

  // New error bits only after the full sense time
  sense_time_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (err_r & ~$past(err_r)) != '0 |-> $past(sense_cnt_r) == SENSE_CNT_W'(OE_ERRDET_CYC))
    else $error("fault captured before sense time");

  // Gain code follows the configuration low byte
  gain_code_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $changed(cfg_r) |=> o_gain_code == cfg_r[GAIN_WIDTH-1:0])
    else $error("gain code mismatch");
endmodule

// file: rtl/led_sink_pkg.sv
// Shared constants for the sixteen-channel LED sink serial control logic
// Summary of operation
// - Serial clock rise shifts data in; strobe high copies register in normal mode; enable high blanks.
// - An enable and strobe sequence enters the special mode from normal operation.
// - In current-adjust mode a strobe pulse writes the 16-bit configuration latch.
// - In error-detection mode a controller sequence lets fault bits shift out.
// - Returning to normal mode clears every error status bit.
// - Low enable turns channels on in every mode.
// - Fault status loads into the shift register, one bit per channel.
// - Configuration code sets a 256-step global gain, 1/12 to 127/128.
// - Undriven strobe reads low and undriven enable reads high.
package led_sink_pkg;
  // Channel count and configuration latch width
  localparam int CHANNELS    = 16;
  localparam int CFG_WIDTH   = 16;
  localparam int GAIN_WIDTH  = 8;
  localparam int FLOG_DEPTH  = 32;

  // Reference clock and enable hold times
  localparam int REF_CLK_MHZ     = 20;
  localparam int OE_NORMAL_NS    = 1000;
  localparam int OE_ERRDET_NS    = 2000;
  localparam int OE_NORMAL_CYC   = (OE_NORMAL_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int OE_ERRDET_CYC   = (OE_ERRDET_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int SENSE_CNT_W     = 7;

  // Reset values; strobe pulled low, enable pulled high
  localparam logic [CHANNELS-1:0]  SR_RST     = 16'h0000;
  localparam logic [CHANNELS-1:0]  LATCH_RST  = 16'h0000;
  localparam logic [CFG_WIDTH-1:0] CFG_RST    = 16'h00ff;
  localparam logic                 STROBE_RST = 1'b0;
  localparam logic                 OE_N_RST   = 1'b1;

  // Sync vector layout: faults in low bits, then clock, data, strobe, enable
  localparam int SYNC_W     = CHANNELS + 4;
  localparam int SY_SCLK    = CHANNELS;
  localparam int SY_SDI     = CHANNELS + 1;
  localparam int SY_STROBE  = CHANNELS + 2;
  localparam int SY_OE_N    = CHANNELS + 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'h8_0000;

  // Operating mode
  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'b00,
    MODE_SPECIAL = 2'b01
  } mode_t;
endpackage

// file: tb/led_sink_host.sv
// Controller model that drives the serial pins of the LED sink
`timescale 1ns/1ps
module led_sink_host (
  // Clock
  input  wire logic i_ref_clk,
  // Serial pins
  output logic      o_serial_clk,
  output logic      o_serial_in,
  output logic      o_latch_strobe,
  output logic      o_output_enable_n
);
  initial begin
    o_serial_clk      = 1'b0;
    o_serial_in       = 1'b0;
    o_latch_strobe    = 1'b0;
    o_output_enable_n = 1'b1;
  end

  // Wait for a number of reference edges
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // One serial bit; phases kept long so the synchroniser sees them
  task automatic clk_bit(input logic b);
    tick(1);
    o_serial_in  <= b;
    tick(3);
    o_serial_clk <= ~o_serial_clk;
    tick(4);
    o_serial_clk <= ~o_serial_clk;
  endtask

  // Whole word, first bit out lands in bit 15
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      clk_bit(w[i]);
    end
  endtask

  // Positive strobe pulse
  task automatic strobe();
    tick(1);
    o_latch_strobe <= ~o_latch_strobe;
    tick(4);
    o_latch_strobe <= ~o_latch_strobe;
  endtask

  // Enable pin level
  task automatic set_oe_n(input logic b);
    tick(1);
    o_output_enable_n <= b;
  endtask

  // one-clock enable pulse, strobe picks the mode
  task automatic mode_switch(input logic sel);
    set_oe_n(1'b0);
    clk_bit(1'b1);
    o_output_enable_n <= 1'b1;
    o_latch_strobe    <= sel;
    clk_bit(1'b1);
    o_latch_strobe    <= 1'b0;
    tick(4);
  endtask

  // long enable pulse, then a rise that loads the status
  task automatic err_load();
    set_oe_n(1'b0);
    clk_bit(1'b1);
    clk_bit(1'b1);
    tick(50);
    o_output_enable_n <= 1'b1;
    tick(4);
    o_serial_clk <= ~o_serial_clk;
    tick(4);
    o_serial_clk <= ~o_serial_clk;
  endtask
endmodule

// file: tb/led_sink_serial_control_bench.sv
// Self-checking testbench for the LED sink serial control logic
`timescale 1ns/1ps
module led_sink_serial_control_bench;
  import led_sink_pkg::*;
  logic        ref_clk    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        fready     = 1'b0;
  logic [15:0] fault      = 16'h0000;
  logic        sclk, serial_in, strobe, oe_n, serial_out, special, fvalid;
  logic [15:0] chans, cfg, fdata, w, f;
  logic [7:0]  gain;
  int          fail_count = 0;
  int          tests_run  = 0;

  // Reference clock, 50 ns period
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Device under test and controller model
  led_sink_ctrl led_sink_ctrl_i (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_serial_clk(sclk), .i_serial_in(serial_in),
    .i_latch_strobe(strobe), .i_output_enable_n(oe_n), .o_serial_out(serial_out),
    .i_channel_fault(fault), .o_sink_channels(chans), .o_cfg_word(cfg),
    .o_gain_code(gain), .o_mode_special(special), .o_flog_valid(fvalid),
    .o_flog_data(fdata), .i_flog_ready(fready));
  led_sink_host led_sink_host_i (
    .i_ref_clk(ref_clk), .o_serial_clk(sclk), .o_serial_in(serial_in),
    .o_latch_strobe(strobe), .o_output_enable_n(oe_n));

  // Verdict and end of run
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Let edges pass, then sample away from them
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Word comparison
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // Single bit comparison
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // Load fault status and shift it out, bit 15 first
  task automatic read_err(input logic [15:0] exp);
    led_sink_host_i.err_load();
    wait_n(4);
    chk1(serial_out, exp[15]);
    for (int i = 14; i >= 0; i--) begin
      led_sink_host_i.clk_bit(1'b0);
      wait_n(4);
      chk1(serial_out, exp[i]);
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hc3ac_e555));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait_n(4);
    chk16(cfg, 16'h00ff);
    chk16({8'h00, gain}, 16'h00ff);
    chk16(chans, 16'h0000);
    chk1(special, 1'b0);
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      led_sink_host_i.send(w);
      led_sink_host_i.strobe();
      led_sink_host_i.set_oe_n(1'b0);
      wait_n(25);
      chk16(chans, w);
      chk1(serial_out, w[15]);
      led_sink_host_i.send(~w);
      wait_n(2);
      chk16(chans, w);
      chk1(serial_out, ~w[15]);
      led_sink_host_i.set_oe_n(1'b1);
      wait_n(4);
      chk16(chans, 16'h0000);
    end
    led_sink_host_i.send(16'hffff);
    led_sink_host_i.strobe();
    led_sink_host_i.mode_switch(1'b1);
    wait_n(2);
    chk1(special, 1'b1);
    w = 16'($urandom);
    led_sink_host_i.send(w);
    led_sink_host_i.strobe();
    wait_n(4);
    chk16(cfg, w);
    chk16({8'h00, gain}, {8'h00, w[7:0]});
    led_sink_host_i.set_oe_n(1'b0);
    wait_n(4);
    chk16(chans, 16'hffff);
    led_sink_host_i.set_oe_n(1'b1);
    f = 16'($urandom) | 16'h8001;
    fault <= f;
    read_err(f);
    chk1(fvalid, 1'b1);
    chk16(fdata, f);
    @(posedge ref_clk);
    fready <= ~fready;
    wait_n(3);
    chk1(fvalid, 1'b0);
    @(posedge ref_clk);
    fready <= ~fready;
    // Faults stay present through the return, so only the clear empties the status
    led_sink_host_i.mode_switch(1'b0);
    wait_n(2);
    chk1(special, 1'b0);
    led_sink_host_i.mode_switch(1'b1);
    fault <= 16'h0000;
    read_err(16'h0000);
    chk1(fvalid, 1'b1);
    chk16(fdata, 16'h0000);
    test_done();
  end

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end
endmodule
